/* File: rtl/apfm_top.sv */
// protection, fault and warning monitor of a four-channel amplifier
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module apfm_top
  import apfm_pkg::*;
#(
  parameter int RAMP_CYCLES_P = RAMP_CYCLES,
  parameter int HICCUP_CYCLES_P = HICCUP_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [DATA_W-1:0] REG_RDATA,
  input wire logic [NCH-1:0] CUR_LIMIT_LO,
  input wire logic [NCH-1:0] CUR_LIMIT_HI,
  input wire logic [NCH-1:0] CUR_SHUTDOWN_LO,
  input wire logic [NCH-1:0] CUR_SHUTDOWN_HI,
  input wire logic [NCH-1:0] DC_OFFSET,
  input wire logic [NCH-1:0] CHANNEL_OVERTEMP_WARNING,
  input wire logic [NCH-1:0] CHANNEL_OVERTEMP_SHUTDOWN,
  input wire logic [3:0] GLOBAL_OVERTEMP_LEVEL,
  input wire logic GLOBAL_OVERTEMP_SHUTDOWN,
  input wire logic SUPPLY_LOW_BATTERY,
  input wire logic SUPPLY_LOW_OUTPUT_STAGE,
  input wire logic SUPPLY_HIGH_EVENT,
  input wire logic CLOCK_ERROR,
  input wire logic MUTE_N,
  input wire logic STANDBY_N,
  input wire logic [NCH-1:0] FULL_DUTY,
  input wire logic PWM_TICK,
  input wire logic [NCH-1:0] DIAG_DONE,
  input wire logic [NCH-1:0] DIAG_LOAD_FAULT,
  output logic [NCH-1:0] PULSE_CUT,
  output logic [NCH-1:0] CH_HIZ,
  output logic [NCH-1:0] CH_MUTE,
  output logic [NCH-1:0] DIAG_START,
  output logic RAMP_DOWN,
  output logic STANDBY_OFF,
  output logic SERIAL_HIZ,
  output logic FAULT_O,
  output logic FAULT_OE_N,
  output logic WARN_O,
  output logic WARN_OE_N
);
  localparam int HC_W = $clog2(HICCUP_CYCLES_P + 1);
  localparam int RP_W = $clog2(RAMP_CYCLES_P + 1);

  // channel-wise match of the two-bit state codes
  function automatic logic [NCH-1:0] st_match(input logic [7:0] ctrl,
                                              input logic [1:0] code);
    logic [NCH-1:0] m;
    m = '0;
    for (int k = 0; k < NCH; k++) begin
      m[k] = (ctrl[2*k +: 2] == code);
    end
    return m;
  endfunction : st_match

  logic [SYNC_W-1:0] sync_q;
  logic [NCH-1:0] lim_lo, lim_hi, sd_lo, sd_hi, dc_s, cotw_s, cotsd_s;
  logic [3:0] gotw_lvl_s;
  logic gotsd_s, low_bat_s, low_stage_s, high_s, clk_err_s;
  logic mute_n_s, stby_n_s;

  apfm_sync #(.W(SYNC_W)) u_sync (
    .clk(REF_CLK),
    .rst(SRST),
    .d({CUR_LIMIT_LO, CUR_LIMIT_HI, CUR_SHUTDOWN_LO, CUR_SHUTDOWN_HI,
        DC_OFFSET, CHANNEL_OVERTEMP_WARNING, CHANNEL_OVERTEMP_SHUTDOWN,
        GLOBAL_OVERTEMP_LEVEL, GLOBAL_OVERTEMP_SHUTDOWN, SUPPLY_LOW_BATTERY,
        SUPPLY_LOW_OUTPUT_STAGE, SUPPLY_HIGH_EVENT, CLOCK_ERROR, MUTE_N,
        STANDBY_N}),
    .q(sync_q)
  );

  assign {lim_lo, lim_hi, sd_lo, sd_hi, dc_s, cotw_s, cotsd_s, gotw_lvl_s,
          gotsd_s, low_bat_s, low_stage_s, high_s, clk_err_s, mute_n_s,
          stby_n_s} = sync_q;

  // register file
  logic [7:0] state_ctrl_r, misc_ctrl_r, fault_mask_r, warn_mask_r;
  logic [NCH-1:0] diag_en_r;
  logic [DATA_W-1:0] rdata_r;
  logic wr_ok, clr_stb, state_wr;
  apfm_sb_t sb_r;

  // the serial port is gone in standby, so writes are dropped there
  assign wr_ok = REG_WR && (sb_r != SB_OFF);
  assign clr_stb = wr_ok && (REG_ADDR == MISC_CTRL3_OFS)
                   && REG_WDATA[MISC_CLEAR_BIT];
  assign state_wr = wr_ok && (REG_ADDR == STATE_CTRL_OFS);

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      state_ctrl_r <= STATE_CTRL_RST;
      misc_ctrl_r <= MISC_CTRL_RST;
      fault_mask_r <= FAULT_MASK_RST;
      warn_mask_r <= WARN_MASK_RST;
      diag_en_r <= DIAG_EN_RST;
    end else if (wr_ok) begin
      case (REG_ADDR)
        STATE_CTRL_OFS: state_ctrl_r <= REG_WDATA;
        MISC_CTRL_OFS: misc_ctrl_r <= REG_WDATA;
        FAULT_MASK_OFS: fault_mask_r <= REG_WDATA;
        WARN_MASK_OFS: warn_mask_r <= REG_WDATA;
        DIAG_CTRL_OFS: diag_en_r <= REG_WDATA[NCH-1:0];
        default: ;
      endcase
    end
  end

  logic ilim_sel;
  logic [NCH-1:0] cmd_play, cmd_mute, cmd_hiz;
  logic [NCH-1:0] cut_hit, sd_hit;

  assign ilim_sel = misc_ctrl_r[MISC_ILIM_SEL_BIT];
  assign cut_hit = ilim_sel ? lim_hi : lim_lo;
  assign sd_hit = ilim_sel ? sd_hi : sd_lo;
  assign cmd_play = st_match(state_ctrl_r, CH_ST_PLAY);
  assign cmd_mute = st_match(state_ctrl_r, CH_ST_MUTE);
  // reserved code falls back to hi-Z
  assign cmd_hiz = ~(cmd_play | cmd_mute);

  logic volt_fault, glob_hiz;
  logic [NCH-1:0] oc_fault_r, dc_fault_r, global_overtemp_shutdown_hold_r, clip_r, pulse_cut_r;
  logic [NCH-1:0] hiz_r, mute_r, diag_start_r, clip_now;
  logic [NCH-1:0] hiz_nxt;

  assign volt_fault = low_bat_s | low_stage_s | high_s;
  // thermal and supply shutdown follow the live level and recover alone
  assign glob_hiz = gotsd_s | volt_fault | (sb_r == SB_OFF);
  assign hiz_nxt = cmd_hiz | oc_fault_r | dc_fault_r | global_overtemp_shutdown_hold_r
                   | {NCH{glob_hiz}};

  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_ch
      apfm_hc_t hc_r;
      logic [HC_W-1:0] hc_cnt_r;
      logic [CLIP_CNT_W-1:0] clip_cnt_r;
      logic oc_set, oc_clr, dc_set;

      // only a driven channel can see load current
      assign oc_set = sd_hit[i] && !hiz_r[i];
      assign oc_clr = (hc_r == HC_DIAG && DIAG_DONE[i]
                       && !DIAG_LOAD_FAULT[i])
                      || (state_wr && hc_r == HC_IDLE);
      assign dc_set = dc_s[i] && cmd_play[i] && !hiz_r[i];

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          oc_fault_r[i] <= 1'b0;
        end else if (oc_set) begin
          oc_fault_r[i] <= 1'b1;
        end else if (oc_clr) begin
          oc_fault_r[i] <= 1'b0;
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          dc_fault_r[i] <= 1'b0;
        end else if (dc_set) begin
          dc_fault_r[i] <= 1'b1;
        end else if (state_wr) begin
          dc_fault_r[i] <= 1'b0;
        end
      end

      // hiccup retry: diagnostics run while the channel is held in hi-Z
      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          hc_r <= HC_IDLE;
          hc_cnt_r <= '0;
          diag_start_r[i] <= 1'b0;
        end else begin
          diag_start_r[i] <= 1'b0;
          case (hc_r)
            HC_IDLE: begin
              if (oc_set && diag_en_r[i]) begin
                hc_r <= HC_DIAG;
                diag_start_r[i] <= 1'b1;
              end
            end
            HC_DIAG: begin
              if (DIAG_DONE[i]) begin
                hc_cnt_r <= '0;
                hc_r <= DIAG_LOAD_FAULT[i] ? HC_WAIT : HC_IDLE;
              end
            end
            HC_WAIT: begin
              if (hc_cnt_r == HC_W'(HICCUP_CYCLES_P - 1)) begin
                hc_r <= HC_DIAG;
                diag_start_r[i] <= 1'b1;
              end else begin
                hc_cnt_r <= hc_cnt_r + 1'b1;
              end
            end
            default: hc_r <= HC_IDLE;
          endcase
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          global_overtemp_shutdown_hold_r[i] <= 1'b0;
        end else if (cotsd_s[i]) begin
          global_overtemp_shutdown_hold_r[i] <= 1'b1;
        end else if (!cotw_s[i]) begin
          global_overtemp_shutdown_hold_r[i] <= 1'b0;
        end
      end

      // counter saturates so a long clip keeps the live level high
      always_ff @(posedge REF_CLK) begin
        if (SRST || !FULL_DUTY[i]) begin
          clip_cnt_r <= '0;
        end else if (PWM_TICK && !clip_now[i]) begin
          clip_cnt_r <= clip_cnt_r + 1'b1;
        end
      end
      assign clip_now[i] = (clip_cnt_r == CLIP_CNT_W'(CLIP_PWM_CLOCKS));

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          clip_r[i] <= 1'b0;
        end else if (clip_now[i]) begin
          clip_r[i] <= 1'b1;
        end else if (clr_stb) begin
          clip_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      hiz_r <= '1;
      mute_r <= '0;
      pulse_cut_r <= '0;
    end else begin
      hiz_r <= hiz_nxt;
      mute_r <= ~hiz_nxt & (cmd_mute | {NCH{!mute_n_s}});
      // limiting trims pulses only and touches no status
      pulse_cut_r <= cut_hit & ~hiz_nxt;
    end
  end

  // standby: ramp active outputs down, then shut down
  logic [RP_W-1:0] ramp_cnt_r;
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      sb_r <= SB_RUN;
      ramp_cnt_r <= '0;
    end else begin
      case (sb_r)
        SB_RUN: begin
          ramp_cnt_r <= '0;
          if (!stby_n_s) begin
            sb_r <= (&hiz_r) ? SB_OFF : SB_RAMP;
          end
        end
        SB_RAMP: begin
          if (ramp_cnt_r == RP_W'(RAMP_CYCLES_P - 1)) begin
            sb_r <= SB_OFF;
          end else begin
            ramp_cnt_r <= ramp_cnt_r + 1'b1;
          end
        end
        SB_OFF: begin
          if (stby_n_s) begin
            sb_r <= SB_RUN;
          end
        end
        default: sb_r <= SB_RUN;
      endcase
    end
  end

  // fault and warning pins
  logic gotw_now, otw_any, global_overtemp_shutdown_any, fault_r, warn_r, por_r, serial_hiz_r;
  logic warn_set;

  assign gotw_now = gotw_lvl_s[misc_ctrl_r[MISC_OTW_LVL_LSB +: 2]];
  assign otw_any = gotw_now | (|cotw_s);
  assign global_overtemp_shutdown_any = gotsd_s | (|global_overtemp_shutdown_hold_r);
  assign warn_set = ((|clip_now) && !warn_mask_r[WM_CLIP_BIT])
                    || (otw_any && !warn_mask_r[WM_OTW_BIT]);

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= ((|(oc_fault_r | dc_fault_r))
                  && !fault_mask_r[FM_CHAN_BIT])
                 || (global_overtemp_shutdown_any && !fault_mask_r[FM_GLOBAL_OVERTEMP_SHUTDOWN_BIT])
                 || (volt_fault && !fault_mask_r[FM_VOLT_BIT])
                 || (clk_err_s && !fault_mask_r[FM_CLK_BIT]);
    end
  end

  // power-on reset leaves the warning pin low until software clears it
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      warn_r <= 1'b1;
    end else if (warn_set) begin
      warn_r <= 1'b1;
    end else if (clr_stb) begin
      warn_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      por_r <= 1'b1;
    end else if (clr_stb) begin
      por_r <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      serial_hiz_r <= 1'b1;
    end else begin
      serial_hiz_r <= (sb_r == SB_OFF);
    end
  end

  // read port: data stand one cycle after the strobe, zero otherwise
  always_ff @(posedge REF_CLK) begin
    if (SRST || !REG_RD) begin
      rdata_r <= '0;
    end else begin
      case (REG_ADDR)
        STATE_CTRL_OFS: rdata_r <= state_ctrl_r;
        MISC_CTRL_OFS: rdata_r <= misc_ctrl_r;
        FAULT_MASK_OFS: rdata_r <= fault_mask_r;
        WARN_MASK_OFS: rdata_r <= warn_mask_r;
        DIAG_CTRL_OFS: rdata_r <= {4'h0, diag_en_r};
        CH_FAULT_STAT_OFS: rdata_r <= {dc_fault_r, oc_fault_r};
        GLB_FAULT_STAT_OFS: rdata_r <= {2'h0, sb_r == SB_OFF, clk_err_s,
                                        high_s, low_stage_s, low_bat_s,
                                        gotsd_s};
        WARN_STAT_OFS: rdata_r <= {2'h0, por_r, gotw_now,
                                   cotw_s};
        CLIP_STAT_OFS: rdata_r <= {clip_now, clip_r};
        CH_LIVE_STAT_OFS: rdata_r <= {global_overtemp_shutdown_hold_r, hiz_r};
        default: rdata_r <= '0;
      endcase
    end
  end

  assign REG_RDATA = rdata_r;
  assign PULSE_CUT = pulse_cut_r;
  assign CH_HIZ = hiz_r;
  assign CH_MUTE = mute_r;
  assign DIAG_START = diag_start_r;
  assign RAMP_DOWN = (sb_r == SB_RAMP);
  assign STANDBY_OFF = (sb_r == SB_OFF);
  assign SERIAL_HIZ = serial_hiz_r;
  // open-drain pins only ever pull low
  assign FAULT_O = 1'b0;
  assign FAULT_OE_N = ~fault_r;
  assign WARN_O = 1'b0;
  assign WARN_OE_N = ~warn_r;
endmodule : apfm_top
`default_nettype wire

/* File: rtl/apfm_pkg.sv */
// constants, codes and state types of the amplifier protection monitor
// Notes on behaviour
// - above current limit, pulses are cut short; no fault, no report
// - limit and shutdown watched per channel; misc bit 4 picks level
// - shutdown level puts channel in hi-Z, sets status, asserts fault
// - with diagnostics on, diagnose then restart, else retry every second
// - with diagnostics off, channel stays hi-Z until the host acts
// - DC offset in play puts channel hi-Z, sets status, maskable fault
// - full duty for 20 PWM clocks on any channel flags clipping
// - clip status is sticky until the clear-fault bit is written
// - clip mask gates the warning pin only, not the status
// - two-bit field picks one of four global warning levels
// - global thermal shutdown: all hi-Z, fault; recovers to register state
// - per-channel thermal warning sets status and warning pin
// - channel thermal shutdown holds hi-Z until below its warning
// - supply low on either supply asserts fault and sets status
// - reset restores defaults, serial port hi-Z, power-on warning set
// - output-stage supply high asserts fault and sets status
// - fault pin follows channel, thermal, supply and clock faults live
// - fault masks gate only the pin; all unmasked after reset
// - clip and thermal warning masks gate the pin; unmasked by default
// - warning pin latches until the clear-fault bit is written
// - mute pin low mutes all channels; undriven pin reads low
// - standby ramps outputs down within 5 ms, then shuts down
package apfm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NCH = 4;

  localparam logic [7:0] STATE_CTRL_OFS = 8'h00;
  localparam logic [7:0] MISC_CTRL_OFS = 8'h01;
  localparam logic [7:0] FAULT_MASK_OFS = 8'h02;
  localparam logic [7:0] WARN_MASK_OFS = 8'h03;
  localparam logic [7:0] DIAG_CTRL_OFS = 8'h04;
  localparam logic [7:0] CH_FAULT_STAT_OFS = 8'h10;
  localparam logic [7:0] GLB_FAULT_STAT_OFS = 8'h11;
  localparam logic [7:0] WARN_STAT_OFS = 8'h12;
  localparam logic [7:0] CLIP_STAT_OFS = 8'h13;
  localparam logic [7:0] CH_LIVE_STAT_OFS = 8'h14;
  localparam logic [7:0] MISC_CTRL3_OFS = 8'h21;

  localparam int MISC_ILIM_SEL_BIT = 4;
  localparam int MISC_OTW_LVL_LSB = 5;
  localparam int MISC_CLEAR_BIT = 7;

  localparam int FM_CHAN_BIT = 0;
  localparam int FM_GLOBAL_OVERTEMP_SHUTDOWN_BIT = 1;
  localparam int FM_VOLT_BIT = 2;
  localparam int FM_CLK_BIT = 3;
  localparam int WM_CLIP_BIT = 0;
  localparam int WM_OTW_BIT = 1;

  localparam logic [7:0] STATE_CTRL_RST = 8'h00;
  localparam logic [7:0] MISC_CTRL_RST = 8'h00;
  localparam logic [7:0] FAULT_MASK_RST = 8'h00;
  localparam logic [7:0] WARN_MASK_RST = 8'h00;
  localparam logic [3:0] DIAG_EN_RST = 4'hF;

  // two bits per channel in the state control register
  localparam logic [1:0] CH_ST_HIZ = 2'h0;
  localparam logic [1:0] CH_ST_MUTE = 2'h1;
  localparam logic [1:0] CH_ST_PLAY = 2'h2;

  localparam int CLIP_PWM_CLOCKS = 20;
  localparam int CLIP_CNT_W = 5;

  localparam int CLK_FREQ_HZ = 125_000_000;
  localparam int RAMP_TIME_US = 5000;
  localparam int HICCUP_TIME_MS = 1000;
  // longest ramp time, rounded down
  localparam int RAMP_CYCLES = RAMP_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int HICCUP_CYCLES = HICCUP_TIME_MS * (CLK_FREQ_HZ / 1000);

  localparam int SYNC_W = 39;

  typedef enum logic [2:0] {
    HC_IDLE = 3'b001,
    HC_DIAG = 3'b010,
    HC_WAIT = 3'b100
  } apfm_hc_t;

  typedef enum logic [2:0] {
    SB_RUN = 3'b001,
    SB_RAMP = 3'b010,
    SB_OFF = 3'b100
  } apfm_sb_t;
endpackage : apfm_pkg

/* File: rtl/apfm_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module apfm_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit only moves once two later stages agree, so one-cycle glitches die
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          q[g] <= 1'b0;
        end else if (s2_r[g] == s3_r[g]) begin
          q[g] <= s3_r[g];
        end
      end
    end
  endgenerate
endmodule : apfm_sync
`default_nettype wire

/* File: test/apfm_asserts.sv */
// port-level assertion checker of the protection monitor
`timescale 1ns/100ps
`default_nettype none
module apfm_asserts
  import apfm_pkg::*;
#(
  parameter int RAMP_CYCLES_P = RAMP_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic SRST,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [DATA_W-1:0] REG_RDATA,
  input wire logic [NCH-1:0] CH_HIZ,
  input wire logic [NCH-1:0] DIAG_START,
  input wire logic RAMP_DOWN,
  input wire logic STANDBY_OFF,
  input wire logic SERIAL_HIZ,
  input wire logic FAULT_OE_N,
  input wire logic WARN_OE_N
);
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);
  logic clr_wr;
  int ramp_cnt;
  assign clr_wr = REG_WR && REG_ADDR == MISC_CTRL3_OFS &&
    REG_WDATA[MISC_CLEAR_BIT];
  always_ff @(posedge REF_CLK) begin
    if (SRST || !RAMP_DOWN) begin
      ramp_cnt <= 0;
    end else begin
      ramp_cnt <= ramp_cnt + 1;
    end
  end
  sequence s_rd_clear;
    REG_RD && REG_ADDR == MISC_CTRL3_OFS;
  endsequence
  // a clear in the last few edges may release the pin
  sequence s_warn_held;
    !WARN_OE_N && !clr_wr && !$past(clr_wr) && !$past(clr_wr, 2);
  endsequence
  chk_reset_vals: assert property ($fell(SRST) |-> CH_HIZ == 4'hF &&
    !WARN_OE_N && FAULT_OE_N && SERIAL_HIZ)
    else $error("outputs off their reset values");
  chk_warn_latch: assert property (s_warn_held |=> !WARN_OE_N)
    else $error("warning pin released without clear");
  chk_clear_reads: assert property (s_rd_clear |=> REG_RDATA == 8'h00)
    else $error("clear bit read back nonzero");
  chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
    else $error("read data outside read slot");
  chk_ramp_bound: assert property (ramp_cnt <= RAMP_CYCLES_P + 1)
    else $error("ramp down too long");
  chk_off_hiz: assert property (STANDBY_OFF && $past(STANDBY_OFF) |->
    CH_HIZ == 4'hF && SERIAL_HIZ)
    else $error("standby without hi-Z");
  chk_diag_pulse: assert property (DIAG_START != 4'h0 |=>
    (DIAG_START & $past(DIAG_START)) == 4'h0)
    else $error("diagnostic start longer than a cycle");
  chk_diag_hiz: assert property (DIAG_START[0] |-> ##[0:1] CH_HIZ[0])
    else $error("diagnostics on a driven channel");
endmodule : apfm_asserts
`default_nettype wire

/* File: test/apfm_host_model.sv */
// host-side pin model: mute pad and open-drain status lines
`timescale 1ns/100ps
`default_nettype none
module apfm_host_model (
  input wire logic mute_en,
  input wire logic mute_lvl,
  input wire logic FAULT_O,
  input wire logic FAULT_OE_N,
  input wire logic WARN_O,
  input wire logic WARN_OE_N,
  output logic MUTE_N,
  output logic fault_line_n,
  output logic warn_line_n
);
  // a released mute pad falls to the pulldown level
  assign MUTE_N = mute_en ? mute_lvl : 1'b0;
  // pullup holds the line high unless the device sinks it
  assign fault_line_n = FAULT_OE_N ? 1'b1 : FAULT_O;
  assign warn_line_n = WARN_OE_N ? 1'b1 : WARN_O;
endmodule : apfm_host_model
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench of the protection monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam int RAMP = 50;
  localparam int HC = 40;
  logic clk = 1'b0;
  logic srst, wr, rd, stb_n, pwm_tick, mute_en, mute_lvl;
  logic [7:0] addr, wd, rdat;
  logic [3:0] lim_lo, lim_hi, sd_lo, sd_hi, dco, cow, cos, lvl, duty;
  logic [3:0] ddone, dlf, pcut, hiz, cmute, dstart;
  logic [4:0] glob;
  logic rdown, soff, shiz, fo, foe, wo, woe, mute_n, fline, wline;
  int bad_count = 0;
  int checked = 0;
  always #4 clk = ~clk;
  apfm_top #(.RAMP_CYCLES_P(RAMP), .HICCUP_CYCLES_P(HC)) apfm_top_i (
    .REF_CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WDATA(wd),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat), .CUR_LIMIT_LO(lim_lo),
    .CUR_LIMIT_HI(lim_hi), .CUR_SHUTDOWN_LO(sd_lo),
    .CUR_SHUTDOWN_HI(sd_hi), .DC_OFFSET(dco),
    .CHANNEL_OVERTEMP_WARNING(cow), .CHANNEL_OVERTEMP_SHUTDOWN(cos),
    .GLOBAL_OVERTEMP_LEVEL(lvl), .GLOBAL_OVERTEMP_SHUTDOWN(glob[0]),
    .SUPPLY_LOW_BATTERY(glob[1]), .SUPPLY_LOW_OUTPUT_STAGE(glob[2]),
    .SUPPLY_HIGH_EVENT(glob[3]), .CLOCK_ERROR(glob[4]), .MUTE_N(mute_n),
    .STANDBY_N(stb_n), .FULL_DUTY(duty), .PWM_TICK(pwm_tick),
    .DIAG_DONE(ddone), .DIAG_LOAD_FAULT(dlf), .PULSE_CUT(pcut),
    .CH_HIZ(hiz), .CH_MUTE(cmute), .DIAG_START(dstart), .RAMP_DOWN(rdown),
    .STANDBY_OFF(soff), .SERIAL_HIZ(shiz), .FAULT_O(fo), .FAULT_OE_N(foe),
    .WARN_O(wo), .WARN_OE_N(woe));
  apfm_host_model apfm_host_model_i (.mute_en(mute_en),
    .mute_lvl(mute_lvl), .FAULT_O(fo), .FAULT_OE_N(foe), .WARN_O(wo),
    .WARN_OE_N(woe), .MUTE_N(mute_n), .fault_line_n(fline),
    .warn_line_n(wline));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] sn, ex);
    checked++;
    if (sn !== ex) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, sn);
    end
  endtask : chk
  task automatic tmo(input int n, lim);
    if (n >= lim) begin
      bad_count++;
      $display("[FAIL] wait bound expected %0d seen %0d", lim, n);
      close_out();
    end
  endtask : tmo
  task automatic wrr(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input string nm, input logic [7:0] a, ex);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(nm, rdat, ex);
    @(posedge clk);
  endtask : rdc
  task automatic clr;
    wrr(8'h21, 8'h80);
    cyc(3);
  endtask : clr
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clk);
      pwm_tick <= 1'b1;
      @(posedge clk);
      pwm_tick <= 1'b0;
    end
  endtask : tk
  task automatic t_reset;
    logic [7:0] ad[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h12,
      8'h21, 8'h30};
    logic [7:0] ex[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h0F, 8'h20,
      8'h00, 8'h00};
    chk("power-on warn", wline, 1'b0);
    chk("fault idle", fline, 1'b1);
    for (int i = 0; i < 8; i++) rdc("reset value", ad[i], ex[i]);
  endtask : t_reset
  task automatic t_clip;
    clr();
    chk("warn cleared", wline, 1'b1);
    rdc("clear bit", 8'h21, 8'h00);
    duty <= 4'h2;
    tk(19);
    cyc(3);
    chk("clip at 19", wline, 1'b1);
    tk(1);
    cyc(3);
    chk("clip at 20", wline, 1'b0);
    duty <= 4'h0;
    cyc(8);
    rdc("clip sticky", 8'h13, 8'h02);
    clr();
    rdc("clip cleared", 8'h13, 8'h00);
    wrr(8'h03, 8'h01);
    duty <= 4'h2;
    tk(20);
    cyc(3);
    chk("clip masked", wline, 1'b1);
    rdc("clip status", 8'h13, 8'h22);
    duty <= 4'h0;
    wrr(8'h03, 8'h00);
    clr();
  endtask : t_clip
  task automatic t_warn;
    cow <= 4'h8;
    cyc(8);
    rdc("chan warn", 8'h12, 8'h08);
    clr();
    chk("set beats clear", wline, 1'b0);
    cow <= 4'h0;
    cyc(8);
    clr();
    for (int k = 0; k < 4; k++) begin
      wrr(8'h01, 8'(k << 5));
      lvl <= 4'(1 << ((k + 1) % 4));
      cyc(8);
      chk("other level", wline, 1'b1);
      lvl <= 4'(1 << k);
      cyc(8);
      chk("chosen level", wline, 1'b0);
      lvl <= 4'h0;
      cyc(8);
      clr();
    end
    wrr(8'h00, 8'hAA);
    wrr(8'h03, 8'h02);
    cow <= 4'h2;
    cos <= 4'h2;
    cyc(8);
    chk("warn masked", wline, 1'b1);
    chk("chan sd hiz", hiz, 4'h2);
    rdc("masked status", 8'h12, 8'h02);
    cos <= 4'h0;
    cyc(8);
    chk("held below warn", hiz, 4'h2);
    cow <= 4'h0;
    cyc(8);
    chk("chan resumes", hiz, 4'h0);
    wrr(8'h03, 8'h00);
  endtask : t_warn
  task automatic t_oc;
    int n;
    sd_lo <= 4'h1;
    for (n = 0; n < 40 && dstart[0] !== 1'b1; n++) @(negedge clk);
    tmo(n, 40);
    cyc(2);
    sd_lo <= 4'h0;
    chk("oc hiz", hiz, 4'h1);
    chk("oc fault pin", fline, 1'b0);
    rdc("oc status", 8'h10, 8'h01);
    ddone <= 4'h1;
    dlf <= 4'h1;
    cyc(1);
    ddone <= 4'h0;
    dlf <= 4'h0;
    for (n = 0; n < 200 && dstart[0] !== 1'b1; n++) @(negedge clk);
    chk("retry gap", 8'(n >= HC - 4 && n <= HC + 6), 8'h01);
    tmo(n, 200);
    cyc(1);
    ddone <= 4'h1;
    cyc(1);
    ddone <= 4'h0;
    cyc(4);
    chk("restarted", hiz, 4'h0);
    chk("fault gone", fline, 1'b1);
  endtask : t_oc
  task automatic t_oc_hi;
    wrr(8'h01, 8'h10);
    wrr(8'h04, 8'h00);
    lim_hi <= 4'h4;
    cyc(8);
    chk("limit cuts", pcut, 4'h4);
    chk("limit silent", fline, 1'b1);
    lim_hi <= 4'h0;
    sd_lo <= 4'h2;
    cyc(8);
    chk("low level unused", hiz, 4'h0);
    sd_lo <= 4'h0;
    sd_hi <= 4'h2;
    cyc(8);
    sd_hi <= 4'h0;
    cyc(HC + 10);
    chk("held hiz", hiz, 4'h2);
    chk("no retry", dstart, 4'h0);
    wrr(8'h00, 8'hAA);
    cyc(3);
    chk("host restart", hiz, 4'h0);
    wrr(8'h01, 8'h00);
    wrr(8'h04, 8'h0F);
  endtask : t_oc_hi
  task automatic t_glob;
    for (int i = 0; i < 5; i++) begin
      glob <= 5'(1 << i);
      cyc(8);
      rdc("global status", 8'h11, 8'(1 << i));
      chk("global fault", fline, 1'b0);
      if (i < 4) chk("global hiz", hiz, 4'hF);
      wrr(8'h02, 8'(1 << ((i == 0) ? 1 : (i == 4) ? 3 : 2)));
      cyc(3);
      chk("masked fault", fline, 1'b1);
      glob <= 5'h00;
      wrr(8'h02, 8'h00);
      cyc(8);
      chk("recovered", hiz, 4'h0);
      chk("fault released", fline, 1'b1);
    end
  endtask : t_glob
  task automatic t_dc;
    dco <= 4'h8;
    cyc(8);
    chk("dc hiz", hiz, 4'h8);
    chk("dc fault", fline, 1'b0);
    rdc("dc status", 8'h10, 8'h80);
    wrr(8'h02, 8'h01);
    cyc(3);
    chk("dc masked", fline, 1'b1);
    dco <= 4'h0;
    cyc(8);
    wrr(8'h00, 8'hAA);
    wrr(8'h02, 8'h00);
    cyc(3);
    chk("dc cleared", hiz, 4'h0);
  endtask : t_dc
  task automatic t_stby;
    int n;
    // released pad must mute every channel
    mute_en <= 1'b0;
    cyc(8);
    chk("pad muted", cmute, 4'hF);
    mute_en <= 1'b1;
    cyc(8);
    chk("unmuted", cmute, 4'h0);
    wrr(8'h00, 8'h5A);
    cyc(3);
    chk("state mute", cmute, 4'hC);
    chk("mute drives", hiz, 4'h0);
    wrr(8'h00, 8'hAA);
    stb_n <= 1'b0;
    for (n = 0; n < 20 && rdown !== 1'b1; n++) @(negedge clk);
    tmo(n, 20);
    for (n = 0; n < 200 && rdown === 1'b1; n++) @(negedge clk);
    chk("ramp length", 8'(n <= RAMP + 1), 8'h01);
    tmo(n, 200);
    cyc(2);
    chk("standby off", soff, 1'b1);
    chk("standby hiz", hiz, 4'hF);
    chk("serial hiz", shiz, 1'b1);
    stb_n <= 1'b1;
    cyc(12);
    chk("awake", soff, 1'b0);
  endtask : t_stby
  initial begin
    {addr, wd, wr, rd, lim_lo, lim_hi, sd_lo, sd_hi, dco, cow} <= '0;
    {cos, lvl, duty, ddone, dlf, glob, pwm_tick} <= '0;
    {srst, stb_n, mute_en, mute_lvl} <= 4'hF;
    cyc(20);
    srst <= 1'b0;
    // inputs pass a synchroniser; standby is seen low briefly
    cyc(12);
    t_reset();
    t_clip();
    t_warn();
    t_oc();
    t_oc_hi();
    t_glob();
    t_dc();
    t_stby();
    // a second reset must undo every register written above
    srst <= 1'b1;
    cyc(2);
    srst <= 1'b0;
    cyc(12);
    t_reset();
    close_out();
  end
endmodule : testbench
bind apfm_top apfm_asserts #(.RAMP_CYCLES_P(RAMP_CYCLES_P)) apfm_asserts_i (
  .REF_CLK(REF_CLK), .SRST(SRST), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .CH_HIZ(CH_HIZ), .DIAG_START(DIAG_START),
  .RAMP_DOWN(RAMP_DOWN), .STANDBY_OFF(STANDBY_OFF),
  .SERIAL_HIZ(SERIAL_HIZ), .FAULT_OE_N(FAULT_OE_N), .WARN_OE_N(WARN_OE_N));
`default_nettype wire
